// >>> ccpc_charge_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ccpc_charge_ctrl #(
	parameter longint unsigned TRICKLE_CYCLES = ccpc_pkg::TRICKLE_TIMEOUT_CYCLES // precharge timeout
) (
	input wire logic clk, // system clock, 100 MHz
	input wire logic nrst, // synchronous reset, active low
	input wire logic supply_low_lockout_clear, // adapter above lockout level
	input wire logic cell_pin_above_precharge, // cell above 2.9V
	input wire logic cell_pin_at_float_voltage, // cell at 4.2V
	input wire logic charge_at_termination, // current down to termination level
	input wire logic cell_pin_below_recharge, // cell below recharge threshold
	input wire logic adapter_supply_droop, // adapter below 4.5V
	input wire logic pack_heat_input_in_window, // thermistor inside safe window
	input wire logic battery_present, // cell connected
	input wire logic die_above_entry, // die at 115 degrees or more
	input wire logic die_below_exit, // die at 95 degrees or less
	input wire logic die_above_regulation, // die above loop regulation point
	input wire logic fault_over_voltage, // battery over-voltage
	input wire logic fault_over_current, // battery over-current
	input wire logic fault_over_temp, // battery over-temperature
	input wire logic charger_on, // charge enable, single-enable variant
	input wire logic load_feed_on, // adapter-to-load enable
	input wire logic battery_feed_on, // battery-to-load enable
	input wire logic mode_sel_a, // select a, two-select variant
	input wire logic mode_sel_b, // select b, two-select variant
	output logic sw_adp_bat, // adapter-to-battery pass switch on
	output logic sw_adp_load, // adapter-to-load pass switch on
	output logic sw_bat_load, // battery-to-load switch on
	output logic trickle_current_on, // reduced preconditioning current
	output logic fast_current_on, // constant current fast charge
	output logic float_voltage_on, // constant voltage regulation
	output logic input_droop_loop, // charge reduced for input droop
	output logic [ccpc_pkg::STEP_W-1:0] thermal_cut, // thermal current reduction steps
	input wire logic charge_indicator_a_in, // charging indicator pin level
	output logic charge_indicator_a_out, // charging indicator drive value
	output logic charge_indicator_a_oe_n, // low pulls the pin down
	input wire logic charge_indicator_b_in, // fault indicator pin level
	output logic charge_indicator_b_out, // fault indicator drive value
	output logic charge_indicator_b_oe_n, // low pulls the pin down
	input wire logic [ccpc_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [ccpc_pkg::ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready // read data ready
);
	import ccpc_pkg::*;
	ccpc_sync_if sif ();
	logic [NSYNC-1:0] q;
	ccpc_state_t st;
	ccpc_state_t next_st;
	logic [1:0] ctrl;
	logic [FLT_W-1:0] fault;
	logic [TIMER_W-1:0] trickle_cnt;
	logic [THERM_CNT_W-1:0] therm_cnt;
	logic therm_on;
	logic damaged;
	logic charging;
	logic fault_now;
	logic charge_allow;
	logic start_ok;
	logic timeout;
	logic adp_bat_dec;
	logic adp_load_dec;
	logic [ADDR_W-1:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic do_write;
	logic [31:0] rd_word;
	logic [1:0] rd_resp;

	// every pin level passes the synchroniser before use
	assign sif.raw = {charge_indicator_b_in, charge_indicator_a_in, mode_sel_b, mode_sel_a,
		battery_feed_on, load_feed_on, charger_on, fault_over_temp, fault_over_current,
		fault_over_voltage, die_above_regulation, die_below_exit, die_above_entry,
		battery_present, pack_heat_input_in_window, adapter_supply_droop,
		cell_pin_below_recharge, charge_at_termination, cell_pin_at_float_voltage,
		cell_pin_above_precharge, supply_low_lockout_clear};
	assign q = sif.qual;
	ccpc_sync u_sync (
		.clk(clk),
		.nrst(nrst),
		.bus(sif.sync)
	);

	// enable decoding for both variants
	assign adp_bat_dec = ctrl[CTRL_TWO_SEL] ? !(q[IN_SEL_A] && q[IN_SEL_B]) : q[IN_CHG_ON];
	assign adp_load_dec = adp_bat_dec && q[IN_LOAD];

	// charge qualification terms
	assign charging = (st == CCPC_TRICKLE) || (st == CCPC_FAST) || (st == CCPC_CV);
	assign fault_now = q[IN_OVP] || q[IN_OCP] || q[IN_OTP] || !q[IN_HEAT];
	assign charge_allow = adp_bat_dec && ctrl[CTRL_SW_EN];
	assign start_ok = q[IN_ADP] && q[IN_HEAT] && q[IN_BATT] && charge_allow && !damaged;
	assign timeout = (trickle_cnt >= TIMER_W'(TRICKLE_CYCLES - 1));

	// charge cycle next state
	always_comb begin
		next_st = st;
		if (!q[IN_ADP]) begin
			next_st = CCPC_IDLE;
		end else if (charging && fault_now) begin
			next_st = CCPC_FAULT;
		end else if (charging && !charge_allow) begin
			next_st = CCPC_IDLE;
		end else begin
			unique case (st)
				CCPC_IDLE: if (start_ok) next_st = q[IN_PRE] ? CCPC_FAST : CCPC_TRICKLE;
				CCPC_TRICKLE: begin
					if (q[IN_PRE]) next_st = CCPC_FAST;
					else if (timeout) next_st = CCPC_FAULT;
				end
				CCPC_FAST: if (q[IN_FLOAT]) next_st = CCPC_CV;
				CCPC_CV: if (q[IN_TERM]) next_st = CCPC_SLEEP;
				CCPC_SLEEP: if (q[IN_RECH]) next_st = CCPC_IDLE;
				CCPC_FAULT: if (!fault_now && !damaged) next_st = CCPC_IDLE;
				default: next_st = CCPC_IDLE;
			endcase
		end
	end

	// state register and phase outputs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st <= CCPC_IDLE;
			trickle_current_on <= 1'b0;
			fast_current_on <= 1'b0;
			float_voltage_on <= 1'b0;
		end else begin
			st <= next_st;
			trickle_current_on <= (next_st == CCPC_TRICKLE);
			fast_current_on <= (next_st == CCPC_FAST);
			float_voltage_on <= (next_st == CCPC_CV);
		end
	end

	// precharge timer and damaged-cell latch, cleared by supply loss
	always_ff @(posedge clk) begin
		if (!nrst) begin
			trickle_cnt <= '0;
			damaged <= 1'b0;
		end else begin
			trickle_cnt <= (st == CCPC_TRICKLE && next_st == CCPC_TRICKLE) ? trickle_cnt + 1'b1 : '0;
			if (!q[IN_ADP]) damaged <= 1'b0;
			else if (st == CCPC_TRICKLE && next_st == CCPC_FAULT && !fault_now) damaged <= 1'b1;
		end
	end

	// pass switches
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sw_adp_bat <= 1'b0;
			sw_adp_load <= 1'b0;
			sw_bat_load <= 1'b0;
		end else begin
			sw_adp_bat <= q[IN_ADP] && adp_bat_dec;
			sw_adp_load <= q[IN_ADP] && adp_load_dec;
			sw_bat_load <= q[IN_BFEED] && (q[IN_ADP] || q[IN_PRE]);
		end
	end

	// input droop and thermal current loops
	always_ff @(posedge clk) begin
		if (!nrst) begin
			input_droop_loop <= 1'b0;
			therm_on <= 1'b0;
			therm_cnt <= '0;
			thermal_cut <= '0;
		end else begin
			input_droop_loop <= (next_st == CCPC_TRICKLE || next_st == CCPC_FAST ||
				next_st == CCPC_CV) && q[IN_DROOP];
			if (therm_on && q[IN_COOL]) begin
				therm_on <= 1'b0;
				therm_cnt <= '0;
				thermal_cut <= '0;
			end else if (!therm_on) begin
				therm_on <= q[IN_HOT];
			end else if (therm_cnt == THERM_CNT_W'(THERM_STEP_CYCLES - 1)) begin
				therm_cnt <= '0;
				if (q[IN_REG] && thermal_cut != STEP_MAX) thermal_cut <= thermal_cut + 1'b1;
				else if (!q[IN_REG] && thermal_cut != '0) thermal_cut <= thermal_cut - 1'b1;
			end else begin
				therm_cnt <= therm_cnt + 1'b1;
			end
		end
	end

	// open-drain indicators: a while charging, b in the fault state
	always_ff @(posedge clk) begin
		if (!nrst) begin
			charge_indicator_a_oe_n <= 1'b1;
			charge_indicator_b_oe_n <= 1'b1;
		end else begin
			charge_indicator_a_oe_n <= !(next_st == CCPC_TRICKLE || next_st == CCPC_FAST ||
				next_st == CCPC_CV);
			charge_indicator_b_oe_n <= !(next_st == CCPC_FAULT);
		end
	end
	assign charge_indicator_a_out = 1'b0;
	assign charge_indicator_b_out = 1'b0;

	// write channel capture; address and data may arrive in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == REG_CTRL || aw_addr == REG_FAULT) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control register and sticky faults; a new fault wins over its clear
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl <= CTRL_RESET;
			fault <= '0;
		end else begin
			if (do_write && aw_addr == REG_CTRL && w_strb[0]) ctrl <= w_data[1:0];
			fault <= (fault & ~((do_write && aw_addr == REG_FAULT && w_strb[0]) ? w_data[FLT_W-1:0] : '0))
				| {damaged, charging && !q[IN_HEAT], charging && q[IN_OTP],
				charging && q[IN_OCP], charging && q[IN_OVP]};
		end
	end

	// read decode
	always_comb begin
		rd_word = '0;
		rd_resp = RESP_OKAY;
		unique case (s_axi_araddr)
			REG_CTRL: rd_word[1:0] = ctrl;
			REG_STATUS: begin
				rd_word[ST_STATE +: 3] = st;
				rd_word[ST_DROOP] = input_droop_loop;
				rd_word[ST_THERM] = therm_on;
				rd_word[ST_STEP +: STEP_W] = thermal_cut;
				rd_word[ST_ADP_BAT] = sw_adp_bat;
				rd_word[ST_ADP_LOAD] = sw_adp_load;
				rd_word[ST_BAT_LOAD] = sw_bat_load;
				rd_word[ST_IND_A] = q[IN_IND_A];
				rd_word[ST_IND_B] = q[IN_IND_B];
			end
			REG_FAULT: rd_word[FLT_W-1:0] = fault;
			default: rd_resp = RESP_SLVERR;
		endcase
	end

	// read channel, one cycle to answer
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_resp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// checks on the charge cycle, switch decode and current loops
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_bat_cut;
		!q[IN_ADP] && !q[IN_PRE] |=> !sw_bat_load;
	endproperty
	a_bat_cut: assert property (p_bat_cut) else $error("battery feeds load below precharge");
	property p_single_load;
		!ctrl[CTRL_TWO_SEL] && q[IN_ADP] && q[IN_CHG_ON] && q[IN_LOAD] |=> sw_adp_load && sw_adp_bat;
	endproperty
	a_single_load: assert property (p_single_load) else $error("adapter switches not on");
	property p_two_off;
		ctrl[CTRL_TWO_SEL] && q[IN_SEL_A] && q[IN_SEL_B] |=> !sw_adp_bat && !sw_adp_load;
	endproperty
	a_two_off: assert property (p_two_off) else $error("adapter switches on with both selects");
	property p_pre_exit;
		st == CCPC_TRICKLE && q[IN_ADP] && !fault_now && charge_allow && q[IN_PRE] |=> st == CCPC_FAST && fast_current_on;
	endproperty
	a_pre_exit: assert property (p_pre_exit) else $error("trickle not left above threshold");
	property p_float;
		st == CCPC_FAST && q[IN_ADP] && !fault_now && charge_allow && q[IN_FLOAT] |=> st == CCPC_CV;
	endproperty
	a_float: assert property (p_float) else $error("constant voltage not entered");
	property p_sleep_hold;
		st == CCPC_SLEEP && q[IN_ADP] && !q[IN_RECH] |=> st == CCPC_SLEEP;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left above recharge");
	property p_fault_stop;
		charging && q[IN_ADP] && fault_now |=> st == CCPC_FAULT && !charge_indicator_b_oe_n;
	endproperty
	a_fault_stop: assert property (p_fault_stop) else $error("fault did not stop charge");
	property p_supply_loss;
		!q[IN_ADP] |=> st == CCPC_IDLE && !trickle_current_on && !fast_current_on && !float_voltage_on;
	endproperty
	a_supply_loss: assert property (p_supply_loss) else $error("charging without supply");
	property p_therm_exit;
		therm_on && q[IN_COOL] |=> !therm_on && thermal_cut == '0;
	endproperty
	a_therm_exit: assert property (p_therm_exit) else $error("thermal loop not reset");
	property p_droop;
		charging && next_st == st && q[IN_DROOP] |=> input_droop_loop;
	endproperty
	a_droop: assert property (p_droop) else $error("droop loop inactive");
endmodule : ccpc_charge_ctrl
`default_nettype wire

// >>> ccpc_pkg.sv
package ccpc_pkg;
	// clock and register bus
	localparam int CLK_PERIOD_NS = 10;
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FAULT = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// control register fields
	localparam int CTRL_TWO_SEL = 0;
	localparam int CTRL_SW_EN = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;
	// status register fields
	localparam int ST_STATE = 0;
	localparam int ST_DROOP = 3;
	localparam int ST_THERM = 4;
	localparam int ST_STEP = 5;
	localparam int ST_ADP_BAT = 8;
	localparam int ST_ADP_LOAD = 9;
	localparam int ST_BAT_LOAD = 10;
	localparam int ST_IND_A = 11;
	localparam int ST_IND_B = 12;
	// sticky fault register fields
	localparam int FLT_OVP = 0;
	localparam int FLT_OCP = 1;
	localparam int FLT_OTP = 2;
	localparam int FLT_PACK = 3;
	localparam int FLT_DAMAGED = 4;
	localparam int FLT_W = 5;
	// timing
	localparam int TRICKLE_TIMEOUT_MIN = 50;
	localparam longint unsigned TRICKLE_TIMEOUT_CYCLES =
		longint'(TRICKLE_TIMEOUT_MIN) * 60 * 1_000_000_000 / CLK_PERIOD_NS;
	localparam int TIMER_W = 40;
	localparam int THERM_STEP_NS = 10_000;
	localparam int THERM_STEP_CYCLES = THERM_STEP_NS / CLK_PERIOD_NS;
	localparam int THERM_CNT_W = 10;
	localparam int STEP_W = 3;
	localparam logic [2:0] STEP_MAX = 3'h7;
	// synchroniser input positions
	localparam int IN_ADP = 0, IN_PRE = 1, IN_FLOAT = 2, IN_TERM = 3, IN_RECH = 4;
	localparam int IN_DROOP = 5, IN_HEAT = 6, IN_BATT = 7, IN_HOT = 8, IN_COOL = 9;
	localparam int IN_REG = 10, IN_OVP = 11, IN_OCP = 12, IN_OTP = 13, IN_CHG_ON = 14;
	localparam int IN_LOAD = 15, IN_BFEED = 16, IN_SEL_A = 17, IN_SEL_B = 18;
	localparam int IN_IND_A = 19, IN_IND_B = 20;
	localparam int NSYNC = 21;
	// charge cycle states
	typedef enum logic [2:0] {
		CCPC_IDLE, CCPC_TRICKLE, CCPC_FAST, CCPC_CV, CCPC_SLEEP, CCPC_FAULT
	} ccpc_state_t;
endpackage : ccpc_pkg

// >>> ccpc_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ccpc_sync_if;
	logic [ccpc_pkg::NSYNC-1:0] raw;
	logic [ccpc_pkg::NSYNC-1:0] qual;
	modport sync (input raw, output qual);
	modport user (output raw, input qual);
endinterface : ccpc_sync_if
`default_nettype wire

// >>> ccpc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ccpc_sync (
	input wire logic clk, // system clock
	input wire logic nrst, // synchronous reset, active low
	ccpc_sync_if.sync bus // raw pins in, qualified levels out
);
	import ccpc_pkg::*;
	logic [NSYNC-1:0] s1;
	logic [NSYNC-1:0] s2;
	logic [NSYNC-1:0] s3;
	logic [NSYNC-1:0] q;
	logic [NSYNC-1:0] next_q;
	// a level is accepted once the second and third stages agree
	for (genvar i = 0; i < NSYNC; i++) begin : g_bit
		assign next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
	end
	// three flop chain; only s2 reads s1
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q <= '0;
		end else begin
			s1 <= bus.raw;
			s2 <= s1;
			s3 <= s2;
			q <= next_q;
		end
	end
	assign bus.qual = q;
endmodule : ccpc_sync
`default_nettype wire

// >>> ccpc_far.sv
`timescale 1ns/1ps
`default_nettype none
module ccpc_far #(
	parameter logic [12:0] RECH_MV = 13'h1004 // recharge level in mV, plain default
) (
	input wire logic [12:0] cell_mv, // cell voltage in mV
	input wire logic term_hit, // cell current has tapered off
	input wire logic cv_on, // device holds constant voltage
	input wire logic a_oe_n, // indicator a pull-down enable
	input wire logic b_oe_n, // indicator b pull-down enable
	output logic above_pre, // cell above 2.9V
	output logic at_float, // cell at 4.2V
	output logic at_term, // current down to termination
	output logic below_rech, // cell below recharge level
	output logic a_pin, // indicator a wire
	output logic b_pin // indicator b wire
);
	// cell comparators as the device sees them
	assign above_pre = cell_mv > 13'hb54;
	assign at_float = cell_mv >= 13'h1068;
	assign at_term = term_hit && cv_on;
	assign below_rech = cell_mv < RECH_MV;
	// led lines have pull-ups, so a released line reads high
	assign a_pin = a_oe_n ? 1'b1 : 1'b0;
	assign b_pin = b_oe_n ? 1'b1 : 1'b0;
endmodule : ccpc_far
`default_nettype wire

// >>> ccpc_charge_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ccpc_charge_ctrl_tb_top;
	import ccpc_pkg::*;
	// ctl bits: 0 adapter, 1 charger_on, 2 load_feed_on, 3 battery_feed_on, 4 sel a, 5 sel b
	logic clk = 1'b0, nrst = 1'b0, batt = 1'b0, droop = 1'b0, term = 1'b0;
	logic d_in = 1'b0, d_out = 1'b0, d_reg = 1'b0;
	logic [5:0] ctl = 6'h0;
	logic [3:0] flt = 4'h0;
	logic [12:0] mv = 13'h9c4;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0, r;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] rdata;
	logic pre, flo, trm, rch, a_oe_n, b_oe_n, a_pin, b_pin, sw_ab, sw_al, sw_bl, tr, fa, cv, dl;
	logic [2:0] cut;
	logic a_out, b_out;
	int fail_count = 0, comparisons = 0, seed = 32'h6c24d477, i, n;
	wire logic [2:0] ph = {tr, fa, cv};

	// free-running 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end

	ccpc_far u_far (.cell_mv(mv), .term_hit(term), .cv_on(cv), .a_oe_n(a_oe_n), .b_oe_n(b_oe_n),
		.above_pre(pre), .at_float(flo), .at_term(trm), .below_rech(rch), .a_pin(a_pin), .b_pin(b_pin));

	ccpc_charge_ctrl #(.TRICKLE_CYCLES(20)) u_dut (.clk(clk), .nrst(nrst), .supply_low_lockout_clear(ctl[0]),
		.cell_pin_above_precharge(pre), .cell_pin_at_float_voltage(flo), .charge_at_termination(trm),
		.cell_pin_below_recharge(rch), .adapter_supply_droop(droop), .pack_heat_input_in_window(!flt[3]),
		.battery_present(batt), .die_above_entry(d_in), .die_below_exit(d_out), .die_above_regulation(d_reg),
		.fault_over_voltage(flt[0]), .fault_over_current(flt[1]), .fault_over_temp(flt[2]),
		.charger_on(ctl[1]), .load_feed_on(ctl[2]), .battery_feed_on(ctl[3]), .mode_sel_a(ctl[4]),
		.mode_sel_b(ctl[5]), .sw_adp_bat(sw_ab), .sw_adp_load(sw_al), .sw_bat_load(sw_bl),
		.trickle_current_on(tr), .fast_current_on(fa), .float_voltage_on(cv), .input_droop_loop(dl),
		.thermal_cut(cut), .charge_indicator_a_in(a_pin), .charge_indicator_a_out(a_out),
		.charge_indicator_a_oe_n(a_oe_n), .charge_indicator_b_in(b_pin), .charge_indicator_b_out(b_out),
		.charge_indicator_b_oe_n(b_oe_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one write: address and data offered together, response taken with bready high
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		k = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && k < 50);
		bready <= 1'b0;
		if (k >= 50) fail_count++;
		if (k >= 50) conclude();
		check(bresp, er);
		@(posedge clk);
	endtask : wr

	// one read, masked compare of data plus the response code
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		int k;
		k = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && k < 50);
		rready <= 1'b0;
		if (k >= 50) fail_count++;
		if (k >= 50) conclude();
		check(rresp, er);
		check(rdata & m, e);
		@(posedge clk);
	endtask : rd

	task automatic step();
		repeat (6) @(posedge clk);
	endtask : step

	// bounded wait for a charge phase pattern {trickle, fast, cv}
	task automatic wait_ph(input logic [2:0] e);
		int k;
		for (k = 0; k < 40 && ph !== e; k++) @(posedge clk);
		check(ph, e);
		if (ph !== e) conclude();
	endtask : wait_ph

	// switch decode: r0 two-select, adapter, charger_on, load, battery feed, a, b, cell high
	function automatic logic [2:0] exp_sw(input logic [7:0] v);
		logic en;
		en = v[0] ? !(v[5] && v[6]) : v[2];
		return {v[1] && en, v[1] && en && v[3], v[4] && (v[1] || v[7])};
	endfunction : exp_sw

	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		step();
		check({sw_ab, sw_al, sw_bl, ph, dl, cut, a_oe_n, b_oe_n}, 12'h003);
		rd(REG_CTRL, 32'hffffffff, 32'h2, RESP_OKAY);
		rd(REG_STATUS, 32'hffffffff, 32'h1800, RESP_OKAY);
		rd(8'h0c, 32'hffffffff, 32'h0, RESP_SLVERR);
		wr(REG_STATUS, 32'h0, RESP_SLVERR);
		wr(8'h10, 32'h3, RESP_SLVERR);
		wr(REG_CTRL, 32'h3, RESP_OKAY);
		rd(REG_CTRL, 32'h3, 32'h3, RESP_OKAY);
		wr(REG_CTRL, 32'h2, RESP_OKAY);
		ctl <= 6'h0f;
		batt <= 1'b1;
		wait_ph(3'h4);
		step();
		check(a_pin, 1'b0);
		rd(REG_STATUS, 32'h7, 32'h1, RESP_OKAY);
		mv <= 13'hdac;
		wait_ph(3'h2);
		check({sw_ab, sw_al, sw_bl}, 3'h7);
		droop <= 1'b1;
		step();
		check(dl, 1'b1);
		droop <= 1'b0;
		step();
		check(dl, 1'b0);
		d_in <= 1'b1;
		d_reg <= 1'b1;
		for (n = 0; n < 1100 && cut !== 3'h1; n++) @(posedge clk);
		check(cut, 3'h1);
		for (n = 0; n < 1100 && cut !== 3'h2; n++) @(posedge clk);
		check((n + 10) / 20, 32'h32);
		d_in <= 1'b0;
		d_reg <= 1'b0;
		d_out <= 1'b1;
		step();
		check(cut, 3'h0);
		d_out <= 1'b0;
		mv <= 13'h1068;
		wait_ph(3'h1);
		term <= 1'b1;
		wait_ph(3'h0);
		mv <= 13'h1036;
		term <= 1'b0;
		repeat (20) @(posedge clk);
		check(ph, 3'h0);
		rd(REG_STATUS, 32'h7, 32'h4, RESP_OKAY);
		mv <= 13'hfa0;
		wait_ph(3'h2);
		ctl[0] <= 1'b0;
		wait_ph(3'h0);
		ctl[0] <= 1'b1;
		wait_ph(3'h2);
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		check({sw_ab, sw_al, sw_bl, ph, dl, cut, a_oe_n, b_oe_n}, 12'h003);
		nrst <= 1'b1;
		wait_ph(3'h2);
		for (i = 0; i < 4; i++) begin
			flt <= 4'h1 << i;
			wait_ph(3'h0);
			step();
			check(b_pin, 1'b0);
			check({a_out, b_out}, 2'h0);
			rd(REG_FAULT, 32'h1 << i, 32'h1 << i, RESP_OKAY);
			flt <= 4'h0;
			step();
			wr(REG_FAULT, 32'h1 << i, RESP_OKAY);
			wait_ph(3'h2);
			check(b_pin, 1'b1);
			rd(REG_FAULT, 32'h1f, 32'h0, RESP_OKAY);
		end
		ctl[0] <= 1'b0;
		mv <= 13'h9c4;
		step();
		ctl[0] <= 1'b1;
		wait_ph(3'h4);
		repeat (30) @(posedge clk);
		check(ph, 3'h0);
		rd(REG_STATUS, 32'h7, 32'h5, RESP_OKAY);
		rd(REG_FAULT, 32'h10, 32'h10, RESP_OKAY);
		batt <= 1'b0;
		for (i = 0; i < 24; i++) begin
			r = $random(seed);
			if (i == 0) r = 32'h7f;
			wr(REG_CTRL, {31'h1, r[0]}, RESP_OKAY);
			ctl <= r[6:1];
			mv <= r[7] ? 13'hdac : 13'h9c4;
			step();
			check({sw_ab, sw_al, sw_bl}, exp_sw(r[7:0]));
			check(ph, 3'h0);
		end
		conclude();
	end
endmodule : ccpc_charge_ctrl_tb_top
`default_nettype wire
